// >>> logic/acs_sequencer.sv
`timescale 1ns/10ps

// Summary of operation
// R1: Result reads left or right justified per the result format select bit.
// R2: Software must set the converter enable before any conversion runs.
// R3: Setting start converts at once or after the programmed acquisition delay.
// R4: Acquisition code 010 samples four conversion clock periods before converting.
// R5: With zero acquisition, conversion waits one instruction after start.
// R6: Software enables and starts the converter in separate writes.
// R7: Completion clears start, sets the done flag and loads the result.
// R8: The capacitor array is discharged after every sample.
// R9: Clearing start mid-conversion aborts and keeps the previous result.
// R10: Reset returns all registers to defaults and ends any conversion.
// R11: After completion or abort wait two periods, then reconnect the channel.
// R12: Software picks clock fields for power-managed modes and keeps the source.
// R13: With the internal oscillator, conversion waits one instruction after start.
// R14: Sleep completion wakes if enabled, else the module powers off.
// R15: Sleep with another clock aborts and powers off, enable stays set.
// R16: Trigger select 0 takes the compare unit, 1 the charge unit.
// R17: The trigger sources must be configured to issue triggers.
// R18: A hardware trigger starts acquisition only while the converter is enabled.
// R19: Module disable holds the converter in reset and stops its clock.
// R20: The five-bit channel field in bits 6 to 2 selects the input.
// R21: Start bit reads one while a conversion cycle is in progress.
// R22: Bit 7 of the channel control register always reads zero.
// R23: Acquisition codes give 0, 2, 4, 6, 8, 12, 16, 20 periods.
// R24: Clock codes select divide by 2, 8, 32, 4, 16, 64 or oscillator.
// R25: A full conversion takes eleven conversion clock periods.
// R26: Left format puts bits 9-2 high; right puts bits 9-8 high.
// R27: The done flag stays set until software clears it.
module acs_sequencer (
  input  wire logic        sys_clk,
  input  wire logic        rst,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        trig_compare,
  input  wire logic        trig_charge,
  input  wire logic        frc_tick,
  input  wire logic        sleep_mode,
  input  wire logic [9:0]  core_result,
  output logic      [4:0]  ana_chan_sel,
  output logic             sample_connect,
  output logic             discharge,
  output logic             convert_run,
  output logic             core_hold_rst,
  output logic             conversion_done_flag,
  output logic             wake_req
);

  function automatic logic [5:0] div_term(input logic [2:0] code);
    case (code)
      3'h0:    div_term = 6'h01;
      3'h1:    div_term = 6'h07;
      3'h2:    div_term = 6'h1f;
      3'h4:    div_term = 6'h03;
      3'h5:    div_term = 6'h0f;
      default: div_term = 6'h3f;
    endcase
  endfunction : div_term

  function automatic logic [4:0] acq_tads(input logic [2:0] code);
    case (code)
      3'h0:    acq_tads = 5'h00;
      3'h1:    acq_tads = 5'h02;
      3'h2:    acq_tads = 5'h04;
      3'h3:    acq_tads = 5'h06;
      3'h4:    acq_tads = 5'h08;
      3'h5:    acq_tads = 5'h0c;
      3'h6:    acq_tads = 5'h10;
      default: acq_tads = 5'h14;
    endcase
  endfunction : acq_tads

  function automatic logic [7:0] fmt_byte(input logic [9:0] res, input logic right, input logic high);
    if (high) begin
      fmt_byte = right ? {6'h00, res[9:8]} : res[9:2];
    end else begin
      fmt_byte = right ? res[7:0] : {res[1:0], 6'h00};
    end
  endfunction : fmt_byte

  acs_pkg::acs_state_t state;
  logic [4:0]          cnt;
  logic [5:0]          div_cnt;
  logic [4:0]          chan;
  logic                conv_en;
  logic                go;
  logic                trig_sel;
  logic [3:0]          ref_cfg;
  logic                fmt_right;
  logic [2:0]          acq_code;
  logic [2:0]          clk_code;
  logic                irq_en;
  logic                mod_dis;
  logic                powered_off;
  logic [9:0]          result;

  logic                bus_req;
  logic                wr;
  logic                rd;
  logic                wr_chan;
  logic                frc_sel;
  logic                tad_tick;
  logic                en;
  logic                busy;
  logic                start;
  logic                abort;
  logic                sleep_abort;
  logic                conv_done;
  logic                hw_trig;
  logic [4:0]          acq_len;

  assign bus_req     = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign wr          = bus_req && wb_we_i && wb_sel_i[0];
  assign rd          = bus_req && !wb_we_i;
  assign wr_chan     = wr && (wb_adr_i == acs_pkg::OFS_CHAN_CTRL);
  assign frc_sel     = (clk_code[1:0] == 2'h3); // [R24]
  assign tad_tick    = frc_sel ? frc_tick : (div_cnt == div_term(clk_code)); // [R24]
  assign en          = conv_en && !powered_off && !mod_dis; // [R2]
  assign busy        = (state == acs_pkg::ST_WAIT) || (state == acs_pkg::ST_ACQ) || (state == acs_pkg::ST_CONV);
  assign acq_len     = acq_tads(acq_code); // [R23]
  assign hw_trig     = trig_sel ? trig_charge : trig_compare; // [R16]
  assign start       = (state == acs_pkg::ST_IDLE) && en && !go &&
                       ((wr_chan && wb_dat_i[acs_pkg::GO_BIT]) || hw_trig); // [R18]
  assign sleep_abort = sleep_mode && !frc_sel && go; // [R15]
  assign abort       = go && ((wr_chan && !wb_dat_i[acs_pkg::GO_BIT]) ||
                       (wr_chan && !wb_dat_i[acs_pkg::EN_BIT]) || sleep_abort); // [R9]
  assign conv_done   = (state == acs_pkg::ST_CONV) && tad_tick &&
                       (cnt == acs_pkg::CONV_TADS - 5'h01) && !abort; // [R25]

  // Bus slave: one wait state, then ack for one cycle.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_ack_o <= 1'b0;
    end else begin
      wb_ack_o <= bus_req;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wb_dat_o <= 32'h00000000;
    end else if (rd) begin
      if (wb_adr_i == acs_pkg::OFS_CHAN_CTRL) begin
        wb_dat_o <= {24'h000000, 1'b0, chan, go, conv_en}; // [R22] [R20] [R21]
      end else if (wb_adr_i == acs_pkg::OFS_TRIG_CTRL) begin
        wb_dat_o <= {24'h000000, trig_sel, 3'h0, ref_cfg};
      end else if (wb_adr_i == acs_pkg::OFS_TIMING) begin
        wb_dat_o <= {24'h000000, fmt_right, 1'b0, acq_code, clk_code};
      end else if (wb_adr_i == acs_pkg::OFS_RES_HIGH) begin
        wb_dat_o <= {24'h000000, fmt_byte(result, fmt_right, 1'b1)}; // [R1] [R26]
      end else if (wb_adr_i == acs_pkg::OFS_RES_LOW) begin
        wb_dat_o <= {24'h000000, fmt_byte(result, fmt_right, 1'b0)}; // [R1] [R26]
      end else if (wb_adr_i == acs_pkg::OFS_SYS_CTRL) begin
        wb_dat_o <= {29'h00000000, mod_dis, irq_en, conversion_done_flag};
      end else begin
        wb_dat_o <= 32'h00000000;
      end
    end
  end

  // Software-owned configuration; module disable holds it at reset, except irq_en and mod_dis.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      chan    <= acs_pkg::CHAN_CTRL_RST[acs_pkg::CHAN_MSB:acs_pkg::CHAN_LSB]; // [R10]
      conv_en <= acs_pkg::CHAN_CTRL_RST[acs_pkg::EN_BIT];
    end else if (mod_dis) begin
      chan    <= acs_pkg::CHAN_CTRL_RST[acs_pkg::CHAN_MSB:acs_pkg::CHAN_LSB]; // [R19]
      conv_en <= acs_pkg::CHAN_CTRL_RST[acs_pkg::EN_BIT];
    end else if (wr_chan) begin
      chan    <= wb_dat_i[acs_pkg::CHAN_MSB:acs_pkg::CHAN_LSB]; // [R20]
      conv_en <= wb_dat_i[acs_pkg::EN_BIT];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      trig_sel <= acs_pkg::REF_RST[4];
      ref_cfg  <= acs_pkg::REF_RST[3:0];
    end else if (mod_dis) begin
      trig_sel <= acs_pkg::REF_RST[4];
      ref_cfg  <= acs_pkg::REF_RST[3:0];
    end else if (wr && (wb_adr_i == acs_pkg::OFS_TRIG_CTRL)) begin
      trig_sel <= wb_dat_i[acs_pkg::TRIG_SEL_BIT]; // [R16]
      ref_cfg  <= wb_dat_i[acs_pkg::REF_MSB:0];
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      fmt_right <= acs_pkg::TIMING_RST[acs_pkg::FMT_BIT];
      acq_code  <= acs_pkg::TIMING_RST[acs_pkg::ACQ_MSB:acs_pkg::ACQ_LSB];
      clk_code  <= acs_pkg::TIMING_RST[acs_pkg::CLK_MSB:0];
    end else if (mod_dis) begin
      fmt_right <= acs_pkg::TIMING_RST[acs_pkg::FMT_BIT];
      acq_code  <= acs_pkg::TIMING_RST[acs_pkg::ACQ_MSB:acs_pkg::ACQ_LSB];
      clk_code  <= acs_pkg::TIMING_RST[acs_pkg::CLK_MSB:0];
    end else if (wr && (wb_adr_i == acs_pkg::OFS_TIMING)) begin
      fmt_right <= wb_dat_i[acs_pkg::FMT_BIT]; // [R1]
      acq_code  <= wb_dat_i[acs_pkg::ACQ_MSB:acs_pkg::ACQ_LSB]; // [R23]
      clk_code  <= wb_dat_i[acs_pkg::CLK_MSB:0]; // [R24]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      irq_en  <= 1'b0;
      mod_dis <= 1'b0;
    end else if (wr && (wb_adr_i == acs_pkg::OFS_SYS_CTRL)) begin
      irq_en  <= wb_dat_i[acs_pkg::IRQ_EN_BIT];
      mod_dis <= wb_dat_i[acs_pkg::MOD_DIS_BIT]; // [R19]
    end
  end

  // Conversion clock divider; it restarts with each sequence so that every period is whole.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      div_cnt <= 6'h00;
    end else if (mod_dis || frc_sel || abort || (state == acs_pkg::ST_IDLE) || (state == acs_pkg::ST_WAIT) ||
                 (div_cnt >= div_term(clk_code))) begin
      div_cnt <= 6'h00; // [R19] [R25] [R11]
    end else begin
      div_cnt <= div_cnt + 6'h01;
    end
  end

  // Sequencer.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state <= acs_pkg::ST_IDLE; // [R10]
      cnt   <= 5'h00;
    end else if (mod_dis) begin
      state <= acs_pkg::ST_IDLE; // [R19]
      cnt   <= 5'h00;
    end else if (abort) begin
      state <= acs_pkg::ST_POST; // [R9] [R15]
      cnt   <= 5'h00;
    end else begin
      case (state)
        acs_pkg::ST_IDLE: begin
          cnt <= 5'h00;
          if (start && ((acq_len == 5'h00) || frc_sel)) begin
            state <= acs_pkg::ST_WAIT; // [R5] [R13]
          end else if (start) begin
            state <= acs_pkg::ST_ACQ; // [R3]
          end
        end
        acs_pkg::ST_WAIT: begin
          if (cnt == acs_pkg::INSTR_CLKS - 5'h01) begin
            cnt   <= 5'h00;
            state <= (acq_len == 5'h00) ? acs_pkg::ST_CONV : acs_pkg::ST_ACQ; // [R3]
          end else begin
            cnt <= cnt + 5'h01;
          end
        end
        acs_pkg::ST_ACQ: begin
          if (tad_tick && (cnt >= acq_len - 5'h01)) begin
            cnt   <= 5'h00;
            state <= acs_pkg::ST_CONV; // [R4]
          end else if (tad_tick) begin
            cnt <= cnt + 5'h01;
          end
        end
        acs_pkg::ST_CONV: begin
          if (conv_done) begin
            cnt   <= 5'h00;
            state <= acs_pkg::ST_POST; // [R25]
          end else if (tad_tick) begin
            cnt <= cnt + 5'h01;
          end
        end
        default: begin
          if (tad_tick && (cnt == acs_pkg::POST_TADS - 5'h01)) begin
            cnt   <= 5'h00;
            state <= acs_pkg::ST_IDLE; // [R11]
          end else if (tad_tick) begin
            cnt <= cnt + 5'h01;
          end
        end
      endcase
    end
  end

  // Start/status bit: set on start, cleared on completion or abort.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      go <= 1'b0;
    end else if (mod_dis || conv_done || abort) begin
      go <= 1'b0; // [R7] [R21]
    end else if (start) begin
      go <= 1'b1; // [R3] [R18]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      result <= acs_pkg::RESULT_RST; // [R10]
    end else if (mod_dis) begin
      result <= acs_pkg::RESULT_RST;
    end else if (conv_done) begin
      result <= core_result; // [R7]
    end
  end

  // Done flag: a completion in the clearing cycle wins.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      conversion_done_flag <= 1'b0;
    end else if (conv_done) begin
      conversion_done_flag <= 1'b1; // [R7] [R27]
    end else if (wr && (wb_adr_i == acs_pkg::OFS_SYS_CTRL) && wb_dat_i[acs_pkg::FLAG_BIT]) begin
      conversion_done_flag <= 1'b0; // [R27]
    end
  end

  // Sleep handling: wake on completion or power the module off.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      powered_off <= 1'b0;
    end else if (!sleep_mode || mod_dis) begin
      powered_off <= 1'b0;
    end else if (sleep_abort || (conv_done && !irq_en)) begin
      powered_off <= 1'b1; // [R14] [R15]
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      wake_req <= 1'b0;
    end else begin
      wake_req <= conv_done && sleep_mode && irq_en; // [R14]
    end
  end

  // Analog side controls.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      sample_connect <= 1'b0;
      discharge      <= 1'b0;
      convert_run    <= 1'b0;
      core_hold_rst  <= 1'b1;
      ana_chan_sel   <= 5'h00;
    end else begin
      sample_connect <= en && ((state == acs_pkg::ST_IDLE) || (state == acs_pkg::ST_ACQ) ||
                        ((state == acs_pkg::ST_WAIT) && (acq_len != 5'h00))); // [R11]
      discharge      <= (state == acs_pkg::ST_POST); // [R8]
      convert_run    <= (state == acs_pkg::ST_CONV);
      core_hold_rst  <= mod_dis || !en; // [R19]
      ana_chan_sel   <= chan; // [R20]
    end
  end

  default clocking cb @(posedge sys_clk);
  endclocking

  default disable iff (rst);

  sequence s_conv_end;
    conv_done;
  endsequence

  sequence s_post_end;
    (state == acs_pkg::ST_POST) && tad_tick && (cnt == 5'h01) && !abort && !mod_dis;
  endsequence

  chk_bit7_zero: assert property ( // [R22]
    rd && (wb_adr_i == acs_pkg::OFS_CHAN_CTRL) |=> wb_dat_o[7] == 1'b0)
    else $error("channel control bit 7 read as one");

  chk_done_effects: assert property ( // [R7]
    s_conv_end |=> conversion_done_flag && !go && (result == $past(core_result)) &&
    (state == acs_pkg::ST_POST))
    else $error("completion did not update flag, start bit and result");

  chk_abort_keeps: assert property ( // [R9]
    abort && !conv_done |=> $stable(result) && !go && (state == acs_pkg::ST_POST))
    else $error("abort changed the result");

  chk_post_reconnect: assert property ( // [R11]
    s_post_end |=> (state == acs_pkg::ST_IDLE) ##1 (sample_connect == en))
    else $error("channel not reconnected after two periods");

  chk_trig_ignored: assert property ( // [R18]
    !en && !go |=> !go)
    else $error("start accepted while converter disabled");

  chk_conv_len: assert property ( // [R25]
    (state == acs_pkg::ST_CONV) |-> cnt < acs_pkg::CONV_TADS)
    else $error("conversion longer than eleven periods");

  chk_acq_len: assert property ( // [R4]
    (state == acs_pkg::ST_ACQ) && (acq_len != 5'h00) |-> cnt < acq_len)
    else $error("acquisition overran its programmed length");

  chk_go_status: assert property ( // [R21]
    go == busy)
    else $error("start bit disagrees with conversion in progress");

  chk_disable_hold: assert property ( // [R19]
    mod_dis |=> (state == acs_pkg::ST_IDLE) && !conv_en && (div_cnt == 6'h00) ##1 core_hold_rst)
    else $error("module disable did not hold the converter");

  chk_fmt_right: assert property ( // [R26]
    rd && (wb_adr_i == acs_pkg::OFS_RES_HIGH) && fmt_right |=> wb_dat_o[7:2] == 6'h00)
    else $error("right justified high byte has upper bits set");

  chk_instr_wait: assert property ( // [R5]
    start && (acq_len == 5'h00) |=> (state == acs_pkg::ST_WAIT)[*4] ##1 (state == acs_pkg::ST_CONV))
    else $error("zero acquisition start skipped the instruction wait");

endmodule : acs_sequencer

// >>> logic/acs_pkg.sv
package acs_pkg;

  // Register byte addresses on the bus.
  localparam logic [7:0] OFS_CHAN_CTRL = 8'h00;
  localparam logic [7:0] OFS_TRIG_CTRL = 8'h04;
  localparam logic [7:0] OFS_TIMING    = 8'h08;
  localparam logic [7:0] OFS_RES_HIGH  = 8'h0c;
  localparam logic [7:0] OFS_RES_LOW   = 8'h10;
  localparam logic [7:0] OFS_SYS_CTRL  = 8'h14;

  // Channel/start control fields.
  localparam int CHAN_LSB     = 2;
  localparam int CHAN_MSB     = 6;
  localparam int GO_BIT       = 1;
  localparam int EN_BIT       = 0;

  // Trigger control fields.
  localparam int TRIG_SEL_BIT = 7;
  localparam int REF_MSB      = 3;

  // Timing control fields.
  localparam int FMT_BIT      = 7;
  localparam int ACQ_LSB      = 3;
  localparam int ACQ_MSB      = 5;
  localparam int CLK_MSB      = 2;

  // System control fields: done flag, wake enable, module disable.
  localparam int FLAG_BIT     = 0;
  localparam int IRQ_EN_BIT   = 1;
  localparam int MOD_DIS_BIT  = 2;

  // Reset values.
  localparam logic [7:0] CHAN_CTRL_RST = 8'h00;
  localparam logic [7:0] TIMING_RST    = 8'h00;
  localparam logic [4:0] REF_RST       = 5'h00;
  localparam logic [9:0] RESULT_RST    = 10'h000;

  // Timing counts.
  localparam logic [4:0] CONV_TADS     = 5'h0b;
  localparam logic [4:0] POST_TADS     = 5'h02;
  localparam logic [4:0] INSTR_CLKS    = 5'h04;

  typedef enum logic [2:0] {
    ST_IDLE,
    ST_WAIT,
    ST_ACQ,
    ST_CONV,
    ST_POST
  } acs_state_t;

endpackage : acs_pkg

// >>> testbench/acs_core_model.sv
`timescale 1ns/10ps

module acs_core_model (
  input  wire logic       sys_clk,
  input  wire logic       rst,
  input  wire logic [4:0] ana_chan_sel,
  input  wire logic       convert_run,
  output logic      [9:0] core_result
);
  logic [9:0] idle_noise;

  // Outside a conversion the output changes every cycle, so a stale sample cannot pass.
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      idle_noise <= 10'h155;
    end else begin
      idle_noise <= ~idle_noise;
    end
  end

  // The converted code is a fixed function of the selected channel.
  assign core_result = convert_run ? {ana_chan_sel, ~ana_chan_sel} : idle_noise;
endmodule : acs_core_model

// >>> testbench/acs_sequencer_tb_top.sv
`timescale 1ns/10ps

module acs_sequencer_tb_top;
  localparam logic [7:0] A_CH = acs_pkg::OFS_CHAN_CTRL;
  localparam logic [7:0] A_TR = acs_pkg::OFS_TRIG_CTRL;
  localparam logic [7:0] A_TM = acs_pkg::OFS_TIMING;
  localparam logic [7:0] A_HI = acs_pkg::OFS_RES_HIGH;
  localparam logic [7:0] A_LO = acs_pkg::OFS_RES_LOW;
  localparam logic [7:0] A_SY = acs_pkg::OFS_SYS_CTRL;
  logic        sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
  logic [7:0]  wb_adr_i;
  logic [3:0]  wb_sel_i;
  logic [31:0] wb_dat_i, wb_dat_o;
  logic        trig_compare, trig_charge, frc_tick, sleep_mode;
  logic [9:0]  core_result, last_r;
  logic [4:0]  ana_chan_sel;
  logic        sample_connect, discharge, convert_run, core_hold_rst, conversion_done_flag, wake_req;
  logic [3:0]  frc_div;
  logic [7:0]  rd_q;
  logic [4:0]  codes [6] = '{5'h00, 5'h1b, 5'h1c, 5'h1d, 5'h1e, 5'h1f};
  int          mismatches, check_count, run_cnt, dis_cnt, wake_cnt, run0, dis0, wake0;

  acs_sequencer u_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i),
    .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .trig_compare(trig_compare), .trig_charge(trig_charge), .frc_tick(frc_tick),
    .sleep_mode(sleep_mode), .core_result(core_result), .ana_chan_sel(ana_chan_sel),
    .sample_connect(sample_connect), .discharge(discharge), .convert_run(convert_run),
    .core_hold_rst(core_hold_rst), .conversion_done_flag(conversion_done_flag), .wake_req(wake_req));
  acs_core_model u_core (.sys_clk(sys_clk), .rst(rst), .ana_chan_sel(ana_chan_sel),
    .convert_run(convert_run), .core_result(core_result));

  initial begin
    sys_clk = 1'b0;
    forever #50 sys_clk = ~sys_clk;
  end

  // Internal oscillator stand-in: one tick every 16 system clocks.
  always @(posedge sys_clk) begin
    frc_div <= rst ? 4'h0 : frc_div + 4'h1;
    frc_tick <= !rst && (frc_div == 4'hf);
  end

  always @(negedge sys_clk) begin
    if (convert_run === 1'b1) run_cnt++;
    if (discharge === 1'b1) dis_cnt++;
    if (wake_req === 1'b1) wake_cnt++;
  end

  task automatic close_out();
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask : close_out

  task automatic give_up(input string msg);
    mismatches++;
    $display("ERROR t=%0t %s", $time, msg);
    close_out();
  endtask : give_up

  task automatic chk8(input logic [7:0] got, input logic [7:0] exp, input string what);
    check_count++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask : chk8

  task automatic chk_num(input int got, input int exp, input string what);
    check_count++;
    if (got != exp) begin
      mismatches++;
      $display("ERROR t=%0t %s got %0d exp %0d", $time, what, got, exp);
    end
  endtask : chk_num

  task automatic bus(input logic [7:0] a, input logic w, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i  <= w;
    wb_adr_i <= a;
    wb_dat_i <= {24'h0, d};
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && n < 16) begin
      n++;
      @(posedge sys_clk);
    end
    if (n == 16) give_up("bus answer missing");
    rd_q = wb_dat_o[7:0];
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
  endtask : bus

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task automatic rd(input logic [7:0] a, input logic [7:0] exp, input string what);
    bus(a, 1'b0, 8'h00);
    chk8(rd_q, exp, what);
  endtask : rd

  task automatic settle();
    int n;
    n = 0;
    @(negedge sys_clk);
    while (discharge !== 1'b0 && n < 400) begin
      n++;
      @(negedge sys_clk);
    end
    if (n == 400) give_up("discharge stuck");
  endtask : settle

  task automatic wait_done();
    int n;
    n = 0;
    bus(A_CH, 1'b0, 8'h00);
    while (rd_q[1] !== 1'b0 && n < 400) begin
      n++;
      bus(A_CH, 1'b0, 8'h00);
    end
    if (n == 400) give_up("start never cleared");
    settle();
  endtask : wait_done

  task automatic wait_run();
    int n;
    n = 0;
    while (convert_run !== 1'b1 && n < 200) begin
      n++;
      @(negedge sys_clk);
    end
    if (n == 200) give_up("conversion never began");
  endtask : wait_run

  task automatic pulse(input logic sel);
    @(posedge sys_clk);
    trig_compare <= ~sel;
    trig_charge <= sel;
    @(posedge sys_clk);
    trig_compare <= 1'b0;
    trig_charge <= 1'b0;
  endtask : pulse

  task automatic run_conv(input logic [4:0] ch, input logic fmt, input logic [2:0] acq, input logic [2:0] clk,
                          input int conversion_clock_period);
    last_r = {ch, ~ch};
    wr(A_TM, {fmt, 1'b0, acq, clk});
    wr(A_CH, {1'b0, ch, 2'b01});
    @(negedge sys_clk);
    chk8({7'h0, core_hold_rst}, 8'h00, "powered");
    run0 = run_cnt;
    dis0 = dis_cnt;
    wr(A_CH, {1'b0, ch, 2'b11});
    rd(A_CH, {1'b0, ch, 2'b11}, "busy");
    wait_done();
    rd(A_CH, {1'b0, ch, 2'b01}, "start cleared");
    rd(A_SY, 8'h01, "done flag");
    rd(A_HI, fmt ? {6'h0, last_r[9:8]} : last_r[9:2], "result high");
    rd(A_LO, fmt ? last_r[7:0] : {last_r[1:0], 6'h0}, "result low");
    chk_num(run_cnt - run0, 11 * conversion_clock_period, "conversion length");
    chk_num(dis_cnt - dis0, 2 * conversion_clock_period, "discharge length");
    @(negedge sys_clk);
    chk8({7'h0, sample_connect}, 8'h01, "reconnected");
    $display("test conversion done");
  endtask : run_conv

  task automatic t_regs();
    chk8({7'h0, core_hold_rst}, 8'h01, "hold at reset");
    rd(A_CH, 8'h00, "chan reset");
    rd(A_TM, 8'h00, "timing reset");
    rd(A_SY, 8'h00, "sys reset");
    wr(8'h3c, 8'h5a);
    rd(8'h3c, 8'h00, "unmapped");
    wr(A_CH, 8'hff);
    rd(A_CH, 8'h7d, "bit7 and same-write start");
    foreach (codes[i]) begin
      wr(A_CH, {1'b0, codes[i], 2'b00});
      @(negedge sys_clk);
      chk8({3'h0, ana_chan_sel}, {3'h0, codes[i]}, "channel pins");
    end
    $display("test registers done");
  endtask : t_regs

  task automatic t_abort();
    wr(A_TM, 8'h06);
    wr(A_CH, 8'h01);
    dis0 = dis_cnt;
    wr(A_CH, 8'h03);
    wait_run();
    wr(A_CH, 8'h01);
    wait_done();
    rd(A_HI, last_r[9:2], "kept high");
    rd(A_LO, {last_r[1:0], 6'h0}, "kept low");
    rd(A_SY, 8'h00, "no flag on abort");
    chk_num(int'((dis_cnt - dis0) > 0 && (dis_cnt - dis0) <= 128), 1, "abort wait");
    $display("test abort done");
  endtask : t_abort

  task automatic t_trig();
    wr(A_TM, 8'h14);
    for (int s = 0; s < 2; s++) begin
      wr(A_TR, {s[0], 7'h0});
      wr(A_CH, 8'h00);
      pulse(s[0]);
      rd(A_CH, 8'h00, "trigger while off");
      wr(A_CH, 8'h01);
      pulse(~s[0]);
      rd(A_CH, 8'h01, "unselected trigger");
      pulse(s[0]);
      rd(A_CH, 8'h03, "trigger starts");
      wait_done();
      rd(A_SY, 8'h01, "trigger flag");
      wr(A_SY, 8'h01);
    end
    wr(A_SY, 8'h04);
    @(negedge sys_clk);
    chk8({7'h0, core_hold_rst}, 8'h01, "disable holds");
    wr(A_CH, 8'h01);
    wr(A_CH, 8'h03);
    bus(A_CH, 1'b0, 8'h00);
    chk8({7'h0, rd_q[1]}, 8'h00, "no start when disabled");
    wr(A_SY, 8'h00);
    $display("test trigger done");
  endtask : t_trig

  task automatic t_sleep();
    wr(A_TM, 8'h00);
    wr(A_CH, 8'h01);
    wr(A_CH, 8'h03);
    wait_run();
    @(posedge sys_clk);
    sleep_mode <= 1'b1;
    bus(A_CH, 1'b0, 8'h00);
    chk8({7'h0, rd_q[0]}, 8'h01, "enable kept");
    chk8({7'h0, core_hold_rst}, 8'h01, "off in sleep");
    rd(A_SY, 8'h00, "no flag");
    @(posedge sys_clk);
    sleep_mode <= 1'b0;
    settle();
    wr(A_TM, 8'h03);
    for (int w = 1; w >= 0; w--) begin
      wr(A_SY, {6'h0, w[0], 1'b1});
      wr(A_CH, 8'h01);
      run0 = run_cnt;
      wake0 = wake_cnt;
      wr(A_CH, 8'h03);
      sleep_mode <= 1'b1;
      for (int n = 0; conversion_done_flag !== 1'b1; n++) begin
        if (n == 1000) give_up("no completion in sleep");
        @(negedge sys_clk);
      end
      repeat (3) @(negedge sys_clk);
      chk_num(wake_cnt - wake0, w, "wake pulses");
      chk_num(int'((run_cnt - run0) > 160 && (run_cnt - run0) <= 176), 1, "oscillator conversion");
      settle();
      chk8({7'h0, core_hold_rst}, {7'h0, ~w[0]}, "sleep power off");
      bus(A_CH, 1'b0, 8'h00);
      chk8({6'h0, rd_q[1:0]}, 8'h01, "enable stays");
      @(posedge sys_clk);
      sleep_mode <= 1'b0;
    end
    $display("test sleep done");
  endtask : t_sleep

  initial begin
    rst = 1'b1;
    {wb_cyc_i, wb_stb_i, wb_we_i, trig_compare, trig_charge, sleep_mode} = 6'h00;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'h1;
    wb_dat_i = 32'h0;
    {mismatches, check_count} = '0;
    repeat (16) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    run_conv(5'h05, 1'b1, 3'b000, 3'h1, 8);
    run_conv(5'h1b, 1'b0, 3'b010, 3'h2, 32);
    run_conv(5'h0a, 1'b1, 3'b111, 3'h5, 16);
    rd(A_SY, 8'h01, "flag sticky");
    wr(A_SY, 8'h01);
    rd(A_SY, 8'h00, "flag cleared");
    t_abort();
    t_trig();
    t_sleep();
    close_out();
  end

  initial begin
    repeat (60000) @(posedge sys_clk);
    give_up("run limit reached");
  end
endmodule : acs_sequencer_tb_top
